// [erb_consts.svh]
// Purpose: named constants for the error recovery budget block
// Assumes: 100 MHz clock
// Notes:   recovery caps held in hundredths of a millisecond
`ifndef ERB_CONSTS_SVH
`define ERB_CONSTS_SVH
`define ERB_CLK_NS        10
`define ERB_MS_NS         1000000
`define ERB_READ_LEVELS   4'hB
`define ERB_WRITE_LEVELS  4'h5
`define ERB_LIMIT_MAX     16'hFFFF
`define ERB_LIMIT_ZERO    16'h0000
`define ERB_CENTI_PER_MS  16'h0064
`define ERB_RCAP0   16'd5187
`define ERB_RCAP1   16'd5985
`define ERB_RCAP2   16'd20349
`define ERB_RCAP3   16'd21945
`define ERB_RCAP4   16'd25311
`define ERB_RCAP5   16'd27935
`define ERB_RCAP6   16'd31127
`define ERB_RCAP7   16'd39512
`define ERB_RCAP8   16'd46312
`define ERB_RCAP9   16'd49504
`define ERB_RCAP10  16'd53095
`define ERB_RCAP11  17'd128297
`define ERB_WCAP0   16'd2394
`define ERB_WCAP1   16'd3591
`define ERB_WCAP2   16'd5586
`define ERB_WCAP3   16'd6783
`define ERB_WCAP4   16'd11979
`define ERB_WCAP5   16'd14772
`endif

// [erb_pkg.sv]
// Purpose: types shared by the error recovery budget design
// Assumes: nothing
// Notes:   constants live in erb_consts.svh
package erb_pkg;
    typedef logic [15:0] ms_t;
    typedef logic [3:0]  level_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STEP,
        ST_DECIDE,
        ST_REALLOC
    } state_t;
endpackage

// [ms_tick.sv]
// Purpose: one-pulse-per-millisecond tick while recovery runs
// Assumes: CYCLES clock periods make one millisecond
// Notes:   the count holds while run is low
`timescale 1ns/10ps
module ms_tick #(
    parameter int CYCLES = 100000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    input  wire logic run,
    output logic      tick
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;

    if (CYCLES < 1) begin : g_chk
        $error("ms_tick: CYCLES must be at least 1");
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (run) begin
                if (cnt_q == W'(CYCLES - 1)) begin
                    cnt_q <= '0;
                    tick  <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule

// [defect_list_mem.sv]
// Purpose: small defect address list, one write and one read port
// Assumes: single clock
// Notes:   read data come out of a register, one cycle after raddr
`timescale 1ns/10ps
module defect_list_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 64
) (
    // clock
    input  wire logic                     clk,
    // write port
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    // read port
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("defect_list_mem: DEPTH >= 2 and WIDTH >= 1 required");
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// [error_recovery_budget.sv]
// Purpose: recovery depth, time budget and reallocation policy
// Assumes: all inputs come from logic on clk
// Notes:   one failing block handled at a time
// Operation
// R1 - eleven read levels, five write levels
// R2 - highest level from the retry count
// R3 - reallocate: enable set, report on, budget left
// R4 - reallocation time not counted against limit
// R5 - suppression blocks all reallocation, recovery continues
// R6 - suppression hides unrecovered errors
// R7 - read per-block cap from read count
// R8 - write per-block cap from write count
// R9 - zero retry count means no recovery
// R10 - limit is two millisecond bytes ten, eleven
// R11 - full limit: per-block caps only
// R12 - timer counts during recovery, clears per command
// R13 - zero limit means maximum; one is smallest
// R14 - factory list frozen, grown list appended
// R15 - initiator reads both defect lists
// R16 - initiator keeps counts at defaults or accepts risk
// R17 - recovery time counted in millisecond ticks
`timescale 1ns/10ps
`include "erb_consts.svh"
module error_recovery_budget #(
    parameter int LBA_W       = 32,
    parameter int DEPTH       = 64,
    parameter int TICK_CYCLES = `ERB_MS_NS / `ERB_CLK_NS
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // mode page settings
    input  wire logic [7:0]         readRetryCount,
    input  wire logic [7:0]         writeRetryCount,
    input  wire logic [7:0]         limitByte10,
    input  wire logic [7:0]         limitByte11,
    input  wire logic               auto_read_reallocate_enable,
    input  wire logic               auto_write_reallocate_enable,
    input  wire logic               suppress_unrecovered_report,
    // command and media events
    input  wire logic               cmdStart,
    input  wire logic               blockError,
    input  wire logic               blockIsWrite,
    input  wire logic [LBA_W-1:0]   blockLba,
    // recovery step engine
    output logic                    stepReq_q,
    output erb_pkg::level_t         stepLevel_q,
    input  wire logic               stepDone,
    input  wire logic               stepOk,
    // reallocation engine
    output logic                    reallocReq_q,
    input  wire logic               reallocDone,
    // block result
    output logic                    blockDone_q,
    output logic                    blockRecovered_q,
    output logic                    reportUnrecovered_q,
    output erb_pkg::ms_t            cmdElapsedMs_q,
    // factory list load, format time only
    input  wire logic               factoryFormat,
    input  wire logic               factoryWrite,
    input  wire logic [LBA_W-1:0]   factoryLba,
    // defect list read
    input  wire logic               defReadReq,
    input  wire logic               defReadGrown,
    input  wire logic [$clog2(DEPTH)-1:0] defReadIdx,
    output logic                    defReadValid_q,
    output logic [LBA_W-1:0]        defReadData_q,
    output logic [$clog2(DEPTH):0]  factoryCount_q,
    output logic [$clog2(DEPTH):0]  grownCount_q
);
    import erb_pkg::*;
    localparam int IW = $clog2(DEPTH);

    if (LBA_W < 1 || DEPTH < 2 || TICK_CYCLES < 1) begin : g_chk
        $error("error_recovery_budget: bad parameter");
    end

    state_t            state_q;
    logic              write_q;
    logic [LBA_W-1:0]  lba_q;
    logic              recov_q;
    ms_t               blkMs_q;
    logic              tick;
    logic              fmtSeen_q;
    logic              factLocked_q;
    logic              rdPend_q;
    logic              rdGrown_q;
    logic [LBA_W-1:0]  factRd;
    logic [LBA_W-1:0]  grownRd;
    ms_t               limitRaw;
    ms_t               limitEff;
    level_t            maxLvl;
    level_t            newLvl;
    logic              blkOver;
    logic              cmdOver;
    logic              reallocOk;
    logic              factWe;
    logic              grownWe;

    // highest level reachable for a direction
    function automatic level_t lvlMax(input logic wr,
                                      input logic [7:0] rr,
                                      input logic [7:0] ww);
        if (wr) begin
            lvlMax = (ww > 8'(`ERB_WRITE_LEVELS)) ? `ERB_WRITE_LEVELS
                                                   : ww[3:0];
        end else begin
            lvlMax = (rr > 8'(`ERB_READ_LEVELS)) ? `ERB_READ_LEVELS
                                                  : rr[3:0];
        end
    endfunction

    // per-block cap, hundredths rounded down to whole ms
    function automatic ms_t capMs(input logic wr, input level_t l);
        logic [16:0] c;
        c = 17'(`ERB_RCAP11);
        if (wr) begin
            unique case (l)
                4'h0: c = 17'(`ERB_WCAP0);
                4'h1: c = 17'(`ERB_WCAP1);
                4'h2: c = 17'(`ERB_WCAP2);
                4'h3: c = 17'(`ERB_WCAP3);
                4'h4: c = 17'(`ERB_WCAP4);
                default: c = 17'(`ERB_WCAP5);
            endcase
        end else begin
            unique case (l)
                4'h0: c = 17'(`ERB_RCAP0);
                4'h1: c = 17'(`ERB_RCAP1);
                4'h2: c = 17'(`ERB_RCAP2);
                4'h3: c = 17'(`ERB_RCAP3);
                4'h4: c = 17'(`ERB_RCAP4);
                4'h5: c = 17'(`ERB_RCAP5);
                4'h6: c = 17'(`ERB_RCAP6);
                4'h7: c = 17'(`ERB_RCAP7);
                4'h8: c = 17'(`ERB_RCAP8);
                4'h9: c = 17'(`ERB_RCAP9);
                4'hA: c = 17'(`ERB_RCAP10);
                default: c = 17'(`ERB_RCAP11);
            endcase
        end
        capMs = 16'(c / 17'(`ERB_CENTI_PER_MS));
    endfunction

    assign limitRaw = {limitByte10, limitByte11};               // see R10
    assign limitEff = (limitRaw == `ERB_LIMIT_ZERO) ? `ERB_LIMIT_MAX
                                                    : limitRaw; // see R13
    assign maxLvl   = lvlMax(write_q, readRetryCount, writeRetryCount);
    assign newLvl   = lvlMax(blockIsWrite, readRetryCount, writeRetryCount);
    // see R7, see R8
    assign blkOver  = blkMs_q >= capMs(write_q, maxLvl);
    // see R11
    assign cmdOver  = (limitEff != `ERB_LIMIT_MAX) &&
                      (cmdElapsedMs_q >= limitEff);
    // see R3, see R5
    assign reallocOk = (write_q ? auto_write_reallocate_enable
                                : auto_read_reallocate_enable) &&
                       !suppress_unrecovered_report && !cmdOver;

    // recovery sequencing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q             <= ST_IDLE;
            write_q             <= 1'b0;
            lba_q               <= '0;
            recov_q             <= 1'b0;
            stepReq_q           <= 1'b0;
            stepLevel_q         <= '0;
            reallocReq_q        <= 1'b0;
            blockDone_q         <= 1'b0;
            blockRecovered_q    <= 1'b0;
            reportUnrecovered_q <= 1'b0;
        end else begin
            blockDone_q         <= 1'b0;
            reportUnrecovered_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (blockError) begin
                        write_q <= blockIsWrite;
                        lba_q   <= blockLba;
                        if (newLvl == 4'h0) begin           // see R9
                            recov_q <= 1'b0;
                            state_q <= ST_DECIDE;
                        end else begin                      // see R1
                            stepLevel_q <= 4'h1;
                            stepReq_q   <= 1'b1;
                            state_q     <= ST_STEP;
                        end
                    end
                end
                ST_STEP: begin
                    if (stepDone) begin
                        if (stepOk) begin
                            recov_q   <= 1'b1;
                            stepReq_q <= 1'b0;
                            state_q   <= ST_DECIDE;
                        end else if (stepLevel_q < maxLvl && !blkOver &&
                                     !cmdOver) begin        // see R2
                            stepLevel_q <= stepLevel_q + 4'h1;
                        end else begin
                            recov_q   <= 1'b0;
                            stepReq_q <= 1'b0;
                            state_q   <= ST_DECIDE;
                        end
                    end
                end
                ST_DECIDE: begin
                    blockDone_q      <= 1'b1;
                    blockRecovered_q <= recov_q;
                    reportUnrecovered_q <= !recov_q &&
                        !suppress_unrecovered_report;       // see R6
                    if (reallocOk) begin                    // see R3
                        reallocReq_q <= 1'b1;
                        state_q      <= ST_REALLOC;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_REALLOC: begin
                    if (reallocDone) begin
                        reallocReq_q <= 1'b0;
                        state_q      <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (state_q == ST_STEP),
        .tick  (tick)
    );

    // recovery timers, advanced only by steps
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmdElapsedMs_q <= '0;
            blkMs_q        <= '0;
        end else begin
            if (cmdStart) begin                             // see R12
                cmdElapsedMs_q <= '0;
            end else if (tick && cmdElapsedMs_q != `ERB_LIMIT_MAX) begin
                cmdElapsedMs_q <= cmdElapsedMs_q + 16'h0001; // see R17
            end
            if (state_q == ST_IDLE && blockError) begin
                blkMs_q <= '0;
            end else if (tick && blkMs_q != `ERB_LIMIT_MAX) begin
                blkMs_q <= blkMs_q + 16'h0001;              // see R4
            end
        end
    end

    // defect lists
    assign factWe  = factoryFormat && factoryWrite && !factLocked_q &&
                     factoryCount_q < (IW+1)'(DEPTH);
    assign grownWe = state_q == ST_REALLOC && reallocDone &&
                     grownCount_q < (IW+1)'(DEPTH);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fmtSeen_q      <= 1'b0;
            factLocked_q   <= 1'b0;
            factoryCount_q <= '0;
            grownCount_q   <= '0;
        end else begin
            fmtSeen_q <= fmtSeen_q | factoryFormat;
            if (fmtSeen_q && !factoryFormat) begin          // see R14
                factLocked_q <= 1'b1;
            end
            if (factWe) begin
                factoryCount_q <= factoryCount_q + 1'b1;
            end
            if (grownWe) begin                              // see R14
                grownCount_q <= grownCount_q + 1'b1;
            end
        end
    end

    defect_list_mem #(.WIDTH(LBA_W), .DEPTH(DEPTH)) u_fact (
        .clk   (clk),
        .we    (factWe),
        .waddr (factoryCount_q[IW-1:0]),
        .wdata (factoryLba),
        .raddr (defReadIdx),
        .rdata (factRd)
    );

    defect_list_mem #(.WIDTH(LBA_W), .DEPTH(DEPTH)) u_grown (
        .clk   (clk),
        .we    (grownWe),
        .waddr (grownCount_q[IW-1:0]),
        .wdata (lba_q),
        .raddr (defReadIdx),
        .rdata (grownRd)
    );

    // defect list read answer, two cycles after the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdPend_q       <= 1'b0;
            rdGrown_q      <= 1'b0;
            defReadValid_q <= 1'b0;
            defReadData_q  <= '0;
        end else begin
            rdPend_q       <= defReadReq;
            rdGrown_q      <= defReadGrown;
            defReadValid_q <= rdPend_q;                     // see R15
            if (rdPend_q) begin
                defReadData_q <= rdGrown_q ? grownRd : factRd;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_suppress_realloc: assert property ( // see R5
        state_q == ST_DECIDE && suppress_unrecovered_report |=>
        !reallocReq_q)
        else $error("reallocation while suppressed");
    a_read_enable: assert property ( // see R3
        state_q == ST_DECIDE && !write_q &&
        !auto_read_reallocate_enable |=> !reallocReq_q)
        else $error("read reallocation without enable");
    a_report_gate: assert property ( // see R6
        reportUnrecovered_q |->
        !$past(suppress_unrecovered_report) && !blockRecovered_q)
        else $error("unrecovered report while suppressed");
    a_zero_retry: assert property ( // see R9
        state_q == ST_IDLE && blockError && newLvl == 4'h0 |=>
        !stepReq_q ##1 blockDone_q && !blockRecovered_q)
        else $error("recovery ran with zero retry count");
    a_level_step: assert property ( // see R1
        state_q == ST_STEP && stepDone && !stepOk &&
        stepLevel_q < maxLvl && !blkOver && !cmdOver |=>
        stepLevel_q == $past(stepLevel_q) + 4'h1)
        else $error("level did not escalate");
    a_level_cap: assert property ( // see R2
        stepReq_q |-> stepLevel_q >= 4'h1 &&
        stepLevel_q <= `ERB_READ_LEVELS)
        else $error("step level out of range");
    a_cmd_clear: assert property ( // see R12
        cmdStart |=> cmdElapsedMs_q == 16'h0000)
        else $error("command timer not cleared");
    a_realloc_time: assert property ( // see R4
        state_q == ST_REALLOC && !cmdStart |=> $stable(cmdElapsedMs_q))
        else $error("reallocation time counted");
    a_zero_limit: assert property ( // see R13
        limitRaw == `ERB_LIMIT_ZERO && state_q == ST_STEP &&
        stepDone && !stepOk && stepLevel_q < maxLvl && !blkOver |=>
        stepLevel_q == $past(stepLevel_q) + 4'h1)
        else $error("zero limit stopped recovery");
    a_grown_add: assert property ( // see R14
        grownWe |=> grownCount_q == $past(grownCount_q) + 1'b1)
        else $error("grown list not appended");
    a_fact_frozen: assert property ( // see R14
        factLocked_q |=> $stable(factoryCount_q))
        else $error("factory list changed");
    a_read_answer: assert property ( // see R15
        defReadReq |-> ##2 defReadValid_q)
        else $error("defect read not answered");

    c_realloc: cover property (reallocReq_q ##[1:20] !reallocReq_q);
    c_unrecovered: cover property (reportUnrecovered_q);
    c_cmd_over: cover property (state_q == ST_STEP && cmdOver);
    c_def_read: cover property (defReadValid_q && rdGrown_q);
endmodule

// [media_engine_model.sv]
// Purpose: media step engine and reallocation engine facing the block
// Assumes: requests are levels held until their done pulse is seen
// Notes:   stepOk toggles outside stepDone so it is never trusted alone
`timescale 1ns/10ps
module media_engine_model (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // behaviour chosen by the bench
    input  wire logic [15:0]     stepCycles,
    input  wire logic [3:0]      okLevel,
    input  wire logic [15:0]     reallocCycles,
    // recovery step engine
    input  wire logic            stepReq_q,
    input  wire erb_pkg::level_t stepLevel_q,
    output logic                 stepDone,
    output logic                 stepOk,
    // reallocation engine
    input  wire logic            reallocReq_q,
    output logic                 reallocDone
);
    import erb_pkg::*;
    logic [15:0] stepCnt;
    logic [15:0] reallocCnt;

    always_ff @(posedge clk) begin
        stepDone    <= 1'b0;
        reallocDone <= 1'b0;
        stepOk      <= ~stepOk;
        if (!rst_n) begin
            stepCnt    <= 16'h0000;
            reallocCnt <= 16'h0000;
            stepOk     <= 1'b0;
        end else begin
            // one reread or rewrite attempt per step
            if (stepReq_q && !stepDone) begin
                stepCnt <= stepCnt + 16'h0001;
                if (stepCnt + 16'h0001 >= stepCycles) begin
                    stepCnt  <= 16'h0000;
                    stepDone <= 1'b1;
                    stepOk   <= (stepLevel_q == okLevel);
                end
            end
            if (reallocReq_q && !reallocDone) begin
                reallocCnt <= reallocCnt + 16'h0001;
                if (reallocCnt + 16'h0001 >= reallocCycles) begin
                    reallocCnt  <= 16'h0000;
                    reallocDone <= 1'b1;
                end
            end
        end
    end
endmodule

// [error_recovery_budget_tb_top.sv]
// Purpose: self-checking bench for the recovery budget block
// Assumes: ten clock cycles make one millisecond tick
// Notes:   outputs are sampled on the falling edge
`timescale 1ns/10ps
module error_recovery_budget_tb_top;
    import erb_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  readRetryCount = 8'h00, writeRetryCount = 8'h00;
    logic [7:0]  limitByte10 = 8'hFF, limitByte11 = 8'hFF;
    logic        auto_read_reallocate_enable = 1'b0;
    logic        auto_write_reallocate_enable = 1'b0;
    logic        suppress_unrecovered_report = 1'b0;
    logic        cmdStart = 1'b0, blockError = 1'b0, blockIsWrite = 1'b0;
    logic [31:0] blockLba = 32'h0, factoryLba = 32'h0, defReadData_q;
    logic        stepReq_q, stepDone, stepOk, reallocReq_q, reallocDone;
    level_t      stepLevel_q;
    logic        blockDone_q, blockRecovered_q, reportUnrecovered_q;
    ms_t         cmdElapsedMs_q, eDone;
    logic        factoryFormat = 1'b0, factoryWrite = 1'b0;
    logic        defReadReq = 1'b0, defReadGrown = 1'b0, defReadValid_q;
    logic [5:0]  defReadIdx = 6'h00;
    logic [6:0]  factoryCount_q, grownCount_q;
    logic [15:0] stepCycles = 16'h0003, reallocCycles = 16'h0004;
    logic [3:0]  okLevel = 4'h0;
    int          errors = 0, checked = 0;

    always #5 clk = ~clk;

    error_recovery_budget #(.TICK_CYCLES(10)) dut_u (
        .clk, .rst_n, .readRetryCount, .writeRetryCount, .limitByte10,
        .limitByte11, .auto_read_reallocate_enable,
        .auto_write_reallocate_enable, .suppress_unrecovered_report,
        .cmdStart, .blockError, .blockIsWrite, .blockLba, .stepReq_q,
        .stepLevel_q, .stepDone, .stepOk, .reallocReq_q, .reallocDone,
        .blockDone_q, .blockRecovered_q, .reportUnrecovered_q,
        .cmdElapsedMs_q, .factoryFormat, .factoryWrite, .factoryLba,
        .defReadReq, .defReadGrown, .defReadIdx, .defReadValid_q,
        .defReadData_q, .factoryCount_q, .grownCount_q
    );

    media_engine_model media_u (
        .clk, .rst_n, .stepCycles, .okLevel, .reallocCycles, .stepReq_q,
        .stepLevel_q, .stepDone, .stepOk, .reallocReq_q, .reallocDone
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cfg(input logic [7:0] rr, input logic [7:0] wr,
                       input logic [15:0] lim, input logic [2:0] fl,
                       input logic [15:0] sc, input logic [3:0] ok);
        @(posedge clk);
        stepCycles <= sc;
        okLevel <= ok;
        readRetryCount <= rr;
        writeRetryCount <= wr;
        {limitByte10, limitByte11} <= lim;
        {suppress_unrecovered_report, auto_write_reallocate_enable,
         auto_read_reallocate_enable} <= fl;
    endtask

    task automatic new_cmd;
        @(posedge clk);
        cmdStart <= 1'b1;
        @(posedge clk);
        cmdStart <= 1'b0;
    endtask

    task automatic fw(input logic [31:0] lba);
        @(posedge clk);
        factoryWrite <= 1'b1;
        factoryLba <= lba;
        @(posedge clk);
        factoryWrite <= 1'b0;
    endtask

    // one failing block, then its reallocation if any
    task automatic blk(input logic wr, input logic [31:0] lba,
                       input logic [3:0] lvl, input logic rec,
                       input logic rep, input logic re);
        logic [3:0] mx;
        logic       sawRe, seen, gotRec, gotRep;
        mx = 4'h0;
        sawRe = 1'b0;
        seen = 1'b0;
        gotRec = 1'b0;
        gotRep = 1'b0;
        @(posedge clk);
        blockError <= 1'b1;
        blockIsWrite <= wr;
        blockLba <= lba;
        @(posedge clk);
        blockError <= 1'b0;
        for (int k = 0; k < 20000; k++) begin
            @(negedge clk);
            if (stepReq_q === 1'b1 && stepLevel_q > mx) mx = stepLevel_q;
            if (reallocReq_q === 1'b1) sawRe = 1'b1;
            if (blockDone_q === 1'b1) begin
                seen = 1'b1;
                gotRec = blockRecovered_q;
                gotRep = reportUnrecovered_q;
                eDone = cmdElapsedMs_q;
            end
            if (seen && reallocReq_q !== 1'b1) break;
        end
        check(seen, 1'b1);
        check(mx, lvl);
        check(gotRec, rec);
        check(gotRep, rep);
        check(sawRe, re);
    endtask

    task automatic rd_def(input logic g, input logic [5:0] idx,
                          input logic [31:0] exp);
        int k;
        k = 0;
        @(posedge clk);
        defReadReq <= 1'b1;
        defReadGrown <= g;
        defReadIdx <= idx;
        @(posedge clk);
        defReadReq <= 1'b0;
        while (k < 6) begin
            @(negedge clk);
            k++;
            if (defReadValid_q === 1'b1) break;
        end
        check(k, 2);
        check(defReadData_q, exp);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({stepReq_q, reallocReq_q, blockDone_q, cmdElapsedMs_q}, 0);
        check({factoryCount_q, grownCount_q}, 0);
        @(posedge clk);
        rst_n <= 1'b1;
        factoryFormat <= 1'b1;
        fw(32'h0000_0A00);
        fw(32'h0000_0A01);
        fw(32'h0000_0A02);
        @(posedge clk);
        factoryFormat <= 1'b0;
        fw(32'h0000_0BAD);
        @(posedge clk);
        factoryFormat <= 1'b1;
        fw(32'h0000_0BAE);
        @(posedge clk);
        factoryFormat <= 1'b0;
        @(negedge clk);
        check(factoryCount_q, 3);
        cfg(8'h03, 8'h02, 16'hFFFF, 3'b001, 16'h0003, 4'h0);
        blk(1'b0, 32'h10, 4'h3, 1'b0, 1'b1, 1'b1);
        blk(1'b1, 32'h14, 4'h2, 1'b0, 1'b1, 1'b0);
        cfg(8'h14, 8'h09, 16'hFFFF, 3'b010, 16'h0003, 4'h0);
        blk(1'b0, 32'h12, 4'hB, 1'b0, 1'b1, 1'b0);
        blk(1'b1, 32'h11, 4'h5, 1'b0, 1'b1, 1'b1);
        cfg(8'h00, 8'h00, 16'hFFFF, 3'b000, 16'h0003, 4'h0);
        blk(1'b0, 32'h13, 4'h0, 1'b0, 1'b1, 1'b0);
        blk(1'b1, 32'h17, 4'h0, 1'b0, 1'b1, 1'b0);
        cfg(8'h03, 8'h05, 16'hFFFF, 3'b111, 16'h0003, 4'h0);
        blk(1'b0, 32'h15, 4'h3, 1'b0, 1'b0, 1'b0);
        blk(1'b1, 32'h16, 4'h5, 1'b0, 1'b0, 1'b0);
        new_cmd();
        reallocCycles <= 16'h01F4;
        cfg(8'h05, 8'h05, 16'hFFFF, 3'b001, 16'h012C, 4'h2);
        blk(1'b0, 32'h20, 4'h2, 1'b1, 1'b0, 1'b1);
        check(cmdElapsedMs_q, eDone);
        check(eDone >= 16'h003B && eDone <= 16'h003D, 1'b1);
        repeat (100) @(negedge clk);
        check(cmdElapsedMs_q, eDone);
        new_cmd();
        @(negedge clk);
        check(cmdElapsedMs_q, 0);
        cfg(8'h0B, 8'h05, 16'hFFFF, 3'b000, 16'h07D0, 4'h0);
        blk(1'b0, 32'h30, 4'h7, 1'b0, 1'b1, 1'b0);
        cfg(8'h0B, 8'h05, 16'hFFFF, 3'b000, 16'h0190, 4'h0);
        blk(1'b1, 32'h31, 4'h4, 1'b0, 1'b1, 1'b0);
        new_cmd();
        cfg(8'h0B, 8'h05, 16'h00C8, 3'b001, 16'h0258, 4'h0);
        blk(1'b0, 32'h40, 4'h4, 1'b0, 1'b1, 1'b0);
        blk(1'b0, 32'h41, 4'h1, 1'b0, 1'b1, 1'b0);
        new_cmd();
        cfg(8'h0B, 8'h05, 16'h0000, 3'b000, 16'h0258, 4'h0);
        blk(1'b0, 32'h42, 4'hB, 1'b0, 1'b1, 1'b0);
        new_cmd();
        cfg(8'h0B, 8'h05, 16'h0001, 3'b000, 16'h0258, 4'h0);
        blk(1'b0, 32'h43, 4'h1, 1'b0, 1'b1, 1'b0);
        check(grownCount_q, 3);
        rd_def(1'b0, 6'h00, 32'h0000_0A00);
        rd_def(1'b0, 6'h01, 32'h0000_0A01);
        rd_def(1'b0, 6'h02, 32'h0000_0A02);
        rd_def(1'b1, 6'h00, 32'h10);
        rd_def(1'b1, 6'h01, 32'h11);
        rd_def(1'b1, 6'h02, 32'h20);
        wrap_up();
    end
endmodule
